//--- inc/flash_wr_consts.svh
/*
 Constants of the flash page buffer write path: copy timing, status
 codes, register offsets, field positions and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FLASH_WR_CONSTS_SVH
`define FLASH_WR_CONSTS_SVH

`define BLK_PER_PAGE 9
`define BLK_BYTES 16
`define RD_CYC 5
`define PB_WR_CYC 1
`define RELOAD_CYC 1
`define COPY_CYC (`BLK_PER_PAGE * (`RD_CYC + `PB_WR_CYC) + `RELOAD_CYC)
`define SW_CYC 3'h4
`define SW_CYC_PIPE 3'h5

`define ST_OK 2'h0
`define ST_PROT 2'h1
`define ST_RANGE 2'h2
`define ST_LOSS 2'h3

`define REG_CTRL 8'h00
`define REG_PROT 8'h04
`define REG_STATE 8'h08
`define REG_ISTAT 8'h0c
`define REG_IMASK 8'h10

`define CTRL_PLP 0
`define CTRL_DROP 1
`define IRQ_DONE 0
`define IRQ_ERR 1

`define CTRL_RST 1'h0
`define PROT_RST 32'h0
`define IMASK_RST 2'h0

`endif

//--- inc/flash_wr_pkg.sv
/*
 Types shared by the flash page buffer write path.
 Assumes nothing of its surroundings.
*/
package flash_wr_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_COPY   = 2'h1,
		ST_SWITCH = 2'h3
	} fsm_t;

	typedef enum logic [1:0] {
		WW_BYTE = 2'h0,
		WW_HALF = 2'h1,
		WW_WORD = 2'h2
	} width_sel_t;

	typedef logic [1:0] status_t;

endpackage

//--- rtl/word_merge.sv
/*
 Merges one byte, halfword or word into a block image.
 Assumes the offset is the byte address inside the block; the word is
 placed on its natural alignment, low bits of the offset are ignored.
*/
`timescale 1ns/1ps
`include "flash_wr_consts.svh"

module word_merge #(
	parameter int BYTES = `BLK_BYTES
) (
	// Block and word.
	input  logic [BYTES*8-1:0]          block_i,
	input  logic [$clog2(BYTES)-1:0]    off_i,
	input  logic [31:0]                 data_i,
	input  flash_wr_pkg::width_sel_t    width_i,
	// Merged block.
	output logic [BYTES*8-1:0]          block_o
);
	import flash_wr_pkg::*;

	localparam int OFF_W = $clog2(BYTES);

	logic [1:0] sh;
	logic [1:0] msk;

	if (BYTES < 4 || (1 << OFF_W) != BYTES)
	begin : g_chk
		$error("Block size must be a power of two of at least four.");
	end

	// A reserved width code is served as a full word.
	assign sh = (width_i == WW_BYTE) ? 2'h0 :
		(width_i == WW_HALF) ? 2'h1 : 2'h2;
	assign msk = (width_i == WW_BYTE) ? 2'h0 :
		(width_i == WW_HALF) ? 2'h1 : 2'h3;

	for (genvar b = 0; b < BYTES; b++)
	begin : g_byte
		localparam logic [OFF_W-1:0] BI = OFF_W'(b);
		logic       hit;
		logic [1:0] lane;
		assign hit = (BI >> sh) == (off_i >> sh);
		assign lane = BI[1:0] & msk;
		// Exactly one word of the selected width lands.
		assign block_o[8*b+:8] = hit ? data_i[8*lane+:8]
			: block_i[8*b+:8];
	end

endmodule

//--- rtl/page_copy_seq.sv
/*
 Sequencer of the page copy from the array into the page buffer.
 Assumes the array answers a block read within the read window and
 that start arrives only while the sequencer is idle.
*/
`timescale 1ns/1ps
`include "flash_wr_consts.svh"

module page_copy_seq (
	// Clock and reset.
	input  logic       clk_i,
	input  logic       rst_i,
	// Control.
	input  logic       start_i,
	output logic       active_o,
	// Array and buffer strobes.
	output logic       rd_o,
	output logic       cap_o,
	output logic       pbwr_o,
	output logic       last_o,
	output logic [3:0] blk_o
);
	typedef struct packed {
		logic       active;
		logic [3:0] blk;
		logic [2:0] ph;
	} seq_t;

	seq_t s_r;
	seq_t s_nxt;
	logic in_page;

	assign in_page = s_r.blk < 4'(`BLK_PER_PAGE);

	// Each block: read phases, then one buffer write.
	assign active_o = s_r.active;
	assign rd_o = s_r.active & in_page & (s_r.ph < 3'(`RD_CYC));
	assign cap_o = s_r.active & in_page & (s_r.ph == 3'(`RD_CYC - 1));
	assign pbwr_o = s_r.active & in_page & (s_r.ph == 3'(`RD_CYC));
	// One closing cycle reloads the target block.
	assign last_o = s_r.active & ~in_page;
	assign blk_o = s_r.blk;

	always_comb
	begin
		s_nxt = s_r;
		if (start_i)
		begin
			s_nxt.active = 1'b1;
			s_nxt.blk = 4'h0;
			s_nxt.ph = 3'h0;
		end
		else if (last_o)
			s_nxt.active = 1'b0;
		else if (s_r.active && s_r.ph == 3'(`RD_CYC))
		begin
			s_nxt.ph = 3'h0;
			s_nxt.blk = s_r.blk + 4'h1;
		end
		else if (s_r.active)
			s_nxt.ph = s_r.ph + 3'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule

//--- rtl/flash_page_wr.sv
/*
 Write path of an embedded flash block: page buffer, block buffer,
 busy handshake, sticky status, and a classic Wishbone slave for
 control, protection map, state and interrupts.
 Assumes user logic drives the write port synchronously to clk_i and
 that the array read port answers within the read window.
*/
`timescale 1ns/1ps
`include "flash_wr_consts.svh"

module flash_page_wr #(
	parameter int PAGE_W = 3
) (
	// Clock and reset.
	input  logic                       clk_i,
	input  logic                       rst_i,
	// User write port.
	input  logic                       wen_i,
	input  logic [PAGE_W+7:0]          addr_i,
	input  logic [31:0]                wdata_i,
	input  flash_wr_pkg::width_sel_t   word_width_select_i,
	input  logic                       pipe_i,
	output logic                       busy_o,
	output flash_wr_pkg::status_t      status_o,
	output logic [`BLK_BYTES*8-1:0]    blk_data_o,
	// Array read port.
	output logic                       arr_rd_o,
	output logic [PAGE_W-1:0]          arr_page_o,
	output logic [3:0]                 arr_blk_o,
	input  logic [`BLK_BYTES*8-1:0]    arr_rdata_i,
	// Wishbone slave.
	input  logic                       wb_cyc_i,
	input  logic                       wb_stb_i,
	input  logic                       wb_we_i,
	input  logic [7:0]                 wb_adr_i,
	input  logic [3:0]                 wb_sel_i,
	input  logic [31:0]                wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	// Interrupt.
	output logic                       irq_o
);
	import flash_wr_pkg::*;

	localparam int PAGES = 1 << PAGE_W;
	localparam int BB = `BLK_BYTES * 8;
	localparam int COPY_D = `COPY_CYC;
	localparam int COPY_D1 = COPY_D + 1;

	typedef struct packed {
		fsm_t              fsm;
		logic [PAGE_W-1:0] page;
		logic              page_vld;
		logic [3:0]        blk;
		logic [3:0]        tblk;
		logic [2:0]        cnt;
		logic [BB-1:0]     blkbuf;
		logic [BB-1:0]     blkreg;
		logic [3:0]        p_off;
		logic [31:0]       p_data;
		width_sel_t        p_w;
		status_t           status;
		logic              plp;
		logic [PAGES-1:0]  prot;
		logic [1:0]        ist;
		logic [1:0]        imsk;
		logic              ack;
		logic [31:0]       rdat;
	} st_t;

	st_t               s_r;
	st_t               s_nxt;
	logic [BB-1:0]     pb_mem [`BLK_PER_PAGE];

	logic              acc;
	logic [PAGE_W-1:0] a_page;
	logic [3:0]        a_blk;
	logic [3:0]        a_off;
	logic              same;
	logic              e_rng;
	logic              e_prot;
	logic              e_loss;
	logic              err;
	logic              k_hit;
	logic              k_sw;
	logic              ok;
	logic              sw_go;
	status_t           st_code;
	logic              seq_start;
	logic              seq_act;
	logic              seq_rd;
	logic              seq_cap;
	logic              seq_pbwr;
	logic              seq_last;
	logic [3:0]        seq_blk;
	logic              idle;
	logic [BB-1:0]     mrg_base;
	logic [3:0]        mrg_off;
	logic [31:0]       mrg_data;
	width_sel_t        mrg_w;
	logic [BB-1:0]     mrg_o;
	logic              wb_wr;
	logic [31:0]       bmask;
	logic [31:0]       prot_w;
	logic [1:0]        ist_clr;
	logic [1:0]        ev;
	logic [31:0]       rd_val;

	if (PAGE_W < 1 || PAGE_W > 5)
	begin : g_chk
		$error("PAGE_W must lie between one and five.");
	end

	// The request is only taken in a cycle where busy is low.
	assign idle = s_r.fsm == ST_IDLE;
	assign acc = wen_i & idle;
	assign busy_o = ~idle;
	assign a_off = addr_i[3:0];
	assign a_blk = addr_i[7:4];
	assign a_page = addr_i[PAGE_W+7:8];

	// Classification of a write; block codes past the page are refused.
	assign same = s_r.page_vld & (a_page == s_r.page);
	assign e_rng = a_blk >= 4'(`BLK_PER_PAGE);
	assign e_prot = s_r.prot[a_page];
	assign e_loss = s_r.plp & s_r.page_vld & ~same;
	assign err = e_rng | e_prot | e_loss;
	assign k_hit = same & (a_blk == s_r.blk);
	assign k_sw = same & ~k_hit;
	assign ok = acc & ~err;
	assign sw_go = ok & k_sw;
	assign seq_start = ok & ~same;
	assign st_code = e_rng ? `ST_RANGE : e_prot ? `ST_PROT
		: e_loss ? `ST_LOSS : `ST_OK;

	page_copy_seq u_seq (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.start_i  (seq_start),
		.active_o (seq_act),
		.rd_o     (seq_rd),
		.cap_o    (seq_cap),
		.pbwr_o   (seq_pbwr),
		.last_o   (seq_last),
		.blk_o    (seq_blk)
	);

	// A hit merges into the live block; otherwise the stored word is
	// merged into the target block as it comes out of the page buffer.
	assign mrg_base = idle ? s_r.blkbuf : pb_mem[s_r.tblk];
	assign mrg_off = idle ? a_off : s_r.p_off;
	assign mrg_data = idle ? wdata_i : s_r.p_data;
	assign mrg_w = idle ? word_width_select_i : s_r.p_w;

	word_merge #(
		.BYTES (`BLK_BYTES)
	) u_merge (
		.block_i (mrg_base),
		.off_i   (mrg_off),
		.data_i  (mrg_data),
		.width_i (mrg_w),
		.block_o (mrg_o)
	);

	// Register bus: one wait state, writes land on the acknowledge edge.
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign prot_w = (32'(s_r.prot) & ~bmask) | (wb_dat_i & bmask);
	assign ist_clr = (wb_wr && wb_adr_i == `REG_ISTAT && wb_sel_i[0])
		? wb_dat_i[1:0] : 2'h0;

	always_comb
	begin
		unique case (wb_adr_i)
			`REG_CTRL:  rd_val = {31'h0, s_r.plp};
			`REG_PROT:  rd_val = 32'(s_r.prot);
			`REG_STATE: rd_val = {16'h0, 8'(s_r.page), s_r.blk,
				s_r.page_vld, s_r.status, busy_o};
			`REG_ISTAT: rd_val = {30'h0, s_r.ist};
			`REG_IMASK: rd_val = {30'h0, s_r.imsk};
			default:    rd_val = 32'h0;
		endcase
	end

	always_comb
	begin
		s_nxt = s_r;
		ev = 2'h0;
		s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
		if (s_nxt.ack)
			s_nxt.rdat = rd_val;
		if (wb_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0])
		begin
			s_nxt.plp = wb_dat_i[`CTRL_PLP];
			// Dropping the buffered page is ignored during an operation.
			if (wb_dat_i[`CTRL_DROP] && idle)
				s_nxt.page_vld = 1'b0;
		end
		if (wb_wr && wb_adr_i == `REG_PROT)
			s_nxt.prot = prot_w[PAGES-1:0];
		if (wb_wr && wb_adr_i == `REG_IMASK && wb_sel_i[0])
			s_nxt.imsk = wb_dat_i[1:0];
		unique case (s_r.fsm)
			ST_IDLE:
				if (acc)
				begin
					// Status changes only when an operation starts.
					s_nxt.status = st_code;
					s_nxt.p_off = a_off;
					s_nxt.p_data = wdata_i;
					s_nxt.p_w = word_width_select_i;
					s_nxt.tblk = a_blk;
					if (err)
						ev[`IRQ_ERR] = 1'b1;
					else if (k_hit)
					begin
						s_nxt.blkbuf = mrg_o;
						ev[`IRQ_DONE] = 1'b1;
					end
					else if (k_sw)
					begin
						s_nxt.fsm = ST_SWITCH;
						s_nxt.cnt = pipe_i ? `SW_CYC_PIPE : `SW_CYC;
					end
					else
					begin
						// The old page is simply replaced; keeping it is up
						// to the user side.
						s_nxt.fsm = ST_COPY;
						s_nxt.page = a_page;
						s_nxt.page_vld = 1'b0;
					end
				end
			ST_COPY:
			begin
				if (seq_cap)
					s_nxt.blkreg = arr_rdata_i;
				if (seq_last)
				begin
					s_nxt.blkbuf = mrg_o;
					s_nxt.blk = s_r.tblk;
					s_nxt.page_vld = 1'b1;
					s_nxt.fsm = ST_IDLE;
					ev[`IRQ_DONE] = 1'b1;
				end
			end
			ST_SWITCH:
			begin
				s_nxt.cnt = s_r.cnt - 3'h1;
				if (s_r.cnt == 3'h1)
				begin
					s_nxt.blkbuf = mrg_o;
					s_nxt.blk = s_r.tblk;
					s_nxt.fsm = ST_IDLE;
					ev[`IRQ_DONE] = 1'b1;
				end
			end
			default:
				s_nxt.fsm = ST_IDLE;
		endcase
		// A new event wins over a clear in the same cycle.
		s_nxt.ist = (s_r.ist & ~ist_clr) | ev;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
			s_r.plp <= `CTRL_RST;
			s_r.prot <= PAGES'(`PROT_RST);
			s_r.imsk <= `IMASK_RST;
		end
		else
			s_r <= s_nxt;
	end

	// The leaving block is written back before the new one is fetched.
	always_ff @(posedge clk_i)
	begin
		if (sw_go)
			pb_mem[s_r.blk] <= s_r.blkbuf;
		else if (seq_pbwr)
			pb_mem[seq_blk] <= s_r.blkreg;
	end

	assign status_o = s_r.status;
	assign blk_data_o = s_r.blkbuf;
	assign arr_rd_o = seq_rd;
	assign arr_page_o = s_r.page;
	assign arr_blk_o = seq_blk;
	assign wb_dat_o = s_r.rdat;
	assign wb_ack_o = s_r.ack;
	assign irq_o = |(s_r.ist & s_r.imsk);

	// Helper counters read only by the checks below.
	logic [6:0] blen_r;
	logic [3:0] wrc_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			blen_r <= 7'h0;
			wrc_r <= 4'h0;
		end
		else
		begin
			blen_r <= busy_o ? blen_r + 7'h1 : 7'h0;
			wrc_r <= seq_start ? 4'h0 : wrc_r + {3'h0, seq_pbwr};
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_miss;
		ok && !same;
	endsequence
	sequence s_sw4;
		sw_go && !pipe_i;
	endsequence
	sequence s_sw5;
		sw_go && pipe_i;
	endsequence

	property p_busy_cause;
		$rose(busy_o) |-> $past(ok);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("Busy rose without an accepted write.");

	property p_no_take_busy;
		busy_o |=> $stable(status_o);
	endproperty
	a_no_take_busy: assert property (p_no_take_busy)
		else $error("Status changed for a request made while busy.");

	property p_copy_len;
		s_miss |-> ##COPY_D1 (!busy_o && blen_r == 7'(COPY_D));
	endproperty
	a_copy_len: assert property (p_copy_len)
		else $error("Page copy busy length is wrong.");

	property p_copy_blocks;
		seq_last |-> wrc_r == 4'(`BLK_PER_PAGE) && !seq_rd;
	endproperty
	a_copy_blocks: assert property (p_copy_blocks)
		else $error("Page copy did not write every block once.");

	property p_hit;
		ok && k_hit |=> !busy_o && blk_data_o == $past(mrg_o);
	endproperty
	a_hit: assert property (p_hit)
		else $error("Same block write raised busy or lost data.");

	property p_sw4;
		s_sw4 |=> busy_o[*4] ##1 !busy_o;
	endproperty
	a_sw4: assert property (p_sw4)
		else $error("Block switch busy is not four cycles.");

	property p_sw5;
		s_sw5 |=> busy_o[*5] ##1 !busy_o;
	endproperty
	a_sw5: assert property (p_sw5)
		else $error("Pipelined block switch busy is not five cycles.");

	property p_ok_status;
		ok |=> status_o == `ST_OK;
	endproperty
	a_ok_status: assert property (p_ok_status)
		else $error("Accepted write did not report success.");

	property p_hold;
		!acc |=> $stable(status_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Status changed without a new operation.");

	property p_prot;
		acc && e_prot && !e_rng |=>
			status_o == `ST_PROT && !busy_o && $stable(blk_data_o);
	endproperty
	a_prot: assert property (p_prot)
		else $error("Protected page write not refused with 01.");

	property p_loss;
		acc && e_loss && !e_prot && !e_rng |=>
			status_o == `ST_LOSS && !busy_o && $stable(s_r.page);
	endproperty
	a_loss: assert property (p_loss)
		else $error("Page loss write not refused with 11.");

endmodule

//--- sim/nv_array_block_model.sv
/*
 Behavioural model of the nonvolatile array read port.
 Assumes the write path reads a block over five cycles and samples
 the data in the fifth; outside reads the bus toggles every cycle.
*/
`timescale 1ns/1ps

module nv_array_block_model #(
	parameter int PAGE_W = 3
) (
	// Clock.
	input  wire logic                clk_i,
	// Read request.
	input  wire logic                arr_rd_i,
	input  wire logic [PAGE_W-1:0]   arr_page_i,
	input  wire logic [3:0]          arr_blk_i,
	// Read data.
	output logic      [127:0]        arr_rdata_o
);
	logic [127:0] data_r = '0;
	int           i;

	assign arr_rdata_o = data_r;

	// Idle data is inverted each cycle so a late sample cannot match.
	always @(posedge clk_i)
	begin
		if (arr_rd_i)
		begin
			for (i = 0; i < 16; i++)
				data_r[i*8+:8] <= 8'(int'(arr_page_i) * 16
					+ int'(arr_blk_i)) ^ 8'(i);
		end
		else
			data_r <= ~data_r;
	end
endmodule

//--- sim/flash_page_buffer_write_tb_top.sv
/*
 Self-checking bench of the flash page buffer write path.
 Assumes the array model answers reads and the design's timing is as
 handed over: hits take no busy cycle, switches four or five, copies 55.
*/
`timescale 1ns/1ps
`include "flash_wr_consts.svh"

module flash_page_buffer_write_tb_top;
	import flash_wr_pkg::*;
	localparam int PW = 3;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          wen_i = 1'b0;
	logic [PW+7:0] addr_i = '0;
	logic [31:0]   wdata_i = '0;
	width_sel_t    ws_i = WW_BYTE;
	logic          pipe_i = 1'b0;
	logic          busy_o;
	status_t       status_o;
	logic [127:0]  blk_o;
	logic          arr_rd;
	logic [PW-1:0] arr_pg;
	logic [3:0]    arr_bk;
	logic [127:0]  arr_dat;
	logic          cyc = 1'b0;
	logic          stb = 1'b0;
	logic          we = 1'b0;
	logic [7:0]    adr = '0;
	logic [3:0]    sel = '0;
	logic [31:0]   dat = '0;
	logic [31:0]   rdat;
	logic          ack;
	logic          irq;
	int            fail_count = 0;
	int            n_compared = 0;
	int            cyc_cnt = 0;
	logic [31:0]   seed = 32'h86416c99;
	logic [127:0]  pb [0:8];
	logic [127:0]  img = '0;
	int            bpage = 0;
	int            bblk = 0;
	bit            bval = 0;
	logic [31:0]   prot = '0;
	bit            plp = 0;

	always #10 clk_i = ~clk_i;

	flash_page_wr #(.PAGE_W(PW)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wen_i(wen_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.word_width_select_i(ws_i), .pipe_i(pipe_i), .busy_o(busy_o),
		.status_o(status_o), .blk_data_o(blk_o), .arr_rd_o(arr_rd),
		.arr_page_o(arr_pg), .arr_blk_o(arr_bk), .arr_rdata_i(arr_dat),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq));

	nv_array_block_model #(.PAGE_W(PW)) array_model (.clk_i(clk_i),
		.arr_rd_i(arr_rd), .arr_page_i(arr_pg), .arr_blk_i(arr_bk),
		.arr_rdata_o(arr_dat));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [127:0] pat(input int p, input int b);
		logic [127:0] r;
		for (int i = 0; i < 16; i++)
			r[i*8+:8] = 8'(p * 16 + b) ^ 8'(i);
		return r;
	endfunction

	function automatic logic [127:0] merge(input logic [127:0] blk,
		input int off, input logic [31:0] d, input width_sel_t w);
		logic [127:0] r;
		int           n;
		int           a;
		r = blk;
		n = (w == WW_BYTE) ? 1 : (w == WW_HALF) ? 2 : 4;
		a = off - off % n;
		for (int i = 0; i < n; i++)
			r[(a+i)*8+:8] = d[i*8+:8];
		return r;
	endfunction

	task automatic chk(input bit ok, input string m);
		n_compared++;
		if (!ok)
		begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bound the run well above the few hundred cycles the tests need.
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 5000)
		begin
			fail_count++;
			results();
		end
	end

	task automatic wbx(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		t = 0;
		do
		begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk(t < 50, "no bus acknowledge");
	endtask

	task automatic wr(input int p, input int b, input int off,
		input logic [31:0] d, input width_sel_t w, input logic pp);
		int      n;
		int      en;
		status_t es;
		es = `ST_OK;
		en = 0;
		if (b > 8)
			es = `ST_RANGE;
		else if (prot[p])
			es = `ST_PROT;
		else if (plp && bval && p != bpage)
			es = `ST_LOSS;
		else if (!bval || p != bpage)
		begin
			en = 55;
			for (int k = 0; k < 9; k++)
				pb[k] = pat(p, k);
			img = merge(pb[b], off, d, w);
			bpage = p;
			bblk = b;
			bval = 1;
		end
		else if (b != bblk)
		begin
			en = pp ? 5 : 4;
			pb[bblk] = img;
			img = merge(pb[b], off, d, w);
			bblk = b;
		end
		else
			img = merge(img, off, d, w);
		// One request carries address, data and width together.
		@(posedge clk_i);
		wen_i <= 1'b1;
		addr_i <= {PW'(p), 4'(b), 4'(off)};
		wdata_i <= d;
		ws_i <= w;
		pipe_i <= pp;
		@(posedge clk_i);
		wen_i <= 1'b0;
		#1;
		n = 0;
		while (busy_o === 1'b1 && n < 100)
		begin
			@(posedge clk_i);
			#1;
			n++;
			// A request made while busy must be ignored by the design.
			if (en > 0 && n == 1)
			begin
				wen_i <= 1'b1;
				addr_i <= {PW'(p), 4'h9, 4'h0};
			end
			if (n == 2)
				wen_i <= 1'b0;
		end
		chk(n == en, "busy length");
		chk(status_o === es, "status");
		chk(blk_o === img, "block data");
	endtask

	initial
	begin
		logic [31:0] q;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(busy_o === 1'b0 && status_o === 2'h0 && irq === 1'b0, "reset");
		wbx(1'b0, `REG_CTRL, '0, q);
		chk(q === 32'h0, "ctrl reset");
		wbx(1'b0, `REG_PROT, '0, q);
		chk(q === `PROT_RST, "prot reset");
		wbx(1'b0, `REG_IMASK, '0, q);
		chk(q === 32'h0, "mask reset");
		wbx(1'b1, 8'hfc, 32'hffff_ffff, q);
		wbx(1'b0, 8'hfc, '0, q);
		chk(q === 32'h0, "unmapped read");
		wbx(1'b1, `REG_IMASK, 32'h3, q);
		wr(2, 3, 5, 32'h1234_5678, WW_WORD, 1'b0);
		@(posedge clk_i);
		#1;
		chk(irq === 1'b1, "irq after write");
		wbx(1'b1, `REG_ISTAT, 32'h3, q);
		@(posedge clk_i);
		#1;
		chk(irq === 1'b0, "irq after clear");
		// Hits every other cycle with every width, reserved code included.
		repeat (12)
		begin
			seed = lfsr(seed);
			wr(2, 3, int'(seed[3:0]), lfsr(seed), width_sel_t'(seed[5:4]),
				seed[6]);
		end
		wr(2, 8, 0, 32'hcafe_f00d, WW_HALF, 1'b0);
		wr(2, 0, 15, 32'h0000_00a5, WW_BYTE, 1'b1);
		wr(2, 8, 2, 32'h0000_003c, WW_BYTE, 1'b0);
		wr(2, 9, 0, 32'h1, WW_BYTE, 1'b0);
		repeat (10) @(posedge clk_i);
		#1;
		chk(status_o === `ST_RANGE, "status held");
		wbx(1'b1, `REG_PROT, 32'h20, q);
		prot = 32'h20;
		wr(5, 1, 0, 32'h55, WW_WORD, 1'b0);
		wbx(1'b1, `REG_CTRL, 32'h1, q);
		plp = 1;
		wr(6, 0, 4, 32'h77, WW_WORD, 1'b0);
		wr(2, 8, 6, 32'h99, WW_BYTE, 1'b0);
		wbx(1'b1, `REG_CTRL, 32'h0, q);
		plp = 0;
		wr(6, 4, 8, 32'h4321_8765, WW_WORD, 1'b1);
		wr(6, 4, 1, 32'h0000_beef, WW_HALF, 1'b0);
		wbx(1'b0, `REG_STATE, '0, q);
		chk(q === 32'h0000_0648, "state register");
		// Dropping the buffered page forces a fresh copy on the next write.
		wbx(1'b1, `REG_CTRL, 32'h2, q);
		bval = 0;
		wr(6, 4, 3, 32'h0000_0011, WW_BYTE, 1'b0);
		results();
	end
endmodule
